// ===== rtl/ssr_defines.vh
// Constants for the segment selector and register unit.
// Assumes inclusion by bare name from rtl/ssr_unit.v.
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH
// Selector fields
`define SSR_IDX_HI 15
`define SSR_IDX_LO 3
`define SSR_TI 2
`define SSR_RPL_HI 1
`define SSR_RPL_LO 0
`define SSR_IDX_W 13
`define SSR_IDX_NULL 13'h0000
// Segment encodings
`define SSR_NSEG 6
`define SSR_SEG_ES 3'h0
`define SSR_SEG_CS 3'h1
`define SSR_SEG_SS 3'h2
`define SSR_SEG_DS 3'h3
`define SSR_SEG_TA 3'h4
`define SSR_SEG_TB 3'h5
// Access kinds
`define SSR_ACC_FETCH 2'h0
`define SSR_ACC_DATA 2'h1
`define SSR_ACC_STRDST 2'h2
`define SSR_ACC_STACK 2'h3
// Fault kinds
`define SSR_FK_NONE 2'h0
`define SSR_FK_LOAD 2'h1
`define SSR_FK_ACCESS 2'h2
`define SSR_FK_BASEWR 2'h3
// Model-specific register addresses of the thread bases
`define SSR_MSR_BASE_A 32'hc0000100
`define SSR_MSR_BASE_B 32'hc0000101
// Descriptor entry layout
`define SSR_D_LIM_LO_HI 15
`define SSR_D_LIM_LO_LO 0
`define SSR_D_BASE_LO_HI 39
`define SSR_D_BASE_LO_LO 16
`define SSR_D_ATTR_HI 55
`define SSR_D_ATTR_LO 40
`define SSR_D_LIM_HI_HI 51
`define SSR_D_LIM_HI_LO 48
`define SSR_D_BASE_HI_HI 63
`define SSR_D_BASE_HI_LO 56
// Attribute bits inside the stored attribute field
`define SSR_AT_DPL_HI 6
`define SSR_AT_DPL_LO 5
`define SSR_AT_L 13
`define SSR_AT_D 14
`define SSR_AT_G 15
// Canonical check: bits 63 down to this one must match
`define SSR_CANON_LO 47
// Widths and reset values
`define SSR_PRIV_USER 2'h3
`define SSR_PRIV_SUPER 2'h0
`define SSR_RST_SEL 16'h0000
`define SSR_RST_BASE 64'h0000000000000000
`define SSR_RST_LIM 20'h00000
`define SSR_RST_ATTR 16'h0000
`define SSR_ZERO32 32'h00000000
`define SSR_ZERO12 12'h000
`define SSR_ONES12 12'hfff
`define SSR_ZERO48 48'h000000000000
`define SSR_DESC_ALIGN 3'h0
`endif

// ===== rtl/ssr_unit.v
// Segment selector decode and segment register file with thread bases.
// Assumes all inputs come from core logic on clock_in; one request of each
// kind per cycle; descriptor entries are fetched by the partner.
//
// Summary of operation
// - Descriptor address is table base plus selector index times eight.
// - Index scaled by eight in long mode too; software aligns wide entries.
// - Table bit clear picks global base, set picks local base.
// - Selector low two bits give requester privilege for privilege checks.
// - Null selector use faults outside 64-bit mode.
// - Null loads: data registers fine; code faults; stack faults outside 64-bit or priv 3.
// - Six 16-bit selector registers at encodings 0 through 5.
// - Each load, except a null load into a thread segment, copies the descriptor entry into the hidden portion.
// - Only thread base fields and code L and D bits of hidden state reachable by software.
// - Code load sets current privilege from its descriptor; fetches use code segment.
// - Data uses default segment; string destinations extra; stack ops stack.
// - 64-bit code: only long, size, privilege used; base zero; canonical check.
// - 64-bit extra, data, stack: base zero, canonical check only.
// - Mode changes never alter segment contents; only loads and thread base writes do.
// - 64-bit thread override adds full base, wraps, canonical check only.
// - Selector load into thread segment writes 32-bit base, upper cleared.
// - Null load into thread segment keeps hidden contents.
// - Thread bases as model registers; privilege 0 writes canonical base.
// - Enabled base-write instructions in 64-bit mode; 32-bit operand zero-extends.
// - Non-canonical base write faults and leaves base unchanged.
// - Compatibility mode uses only low 32 base bits.
`include "ssr_defines.vh"

module ssr_unit (
  // Clock and reset
  input wire clock_in,
  input wire resetn_in,
  // Mode and control
  input wire mode64_in,
  input wire user_base_write_enable_in,
  // Descriptor address decode
  input wire dec_valid_in,
  input wire [15:0] dec_sel_in,
  input wire [63:0] gdt_base_in,
  input wire [63:0] ldt_base_in,
  output reg dec_valid_out,
  output reg [63:0] desc_addr_out,
  // Segment register load
  input wire ld_valid_in,
  input wire [2:0] ld_seg_in,
  input wire [15:0] ld_sel_in,
  input wire [63:0] ld_desc_in,
  output reg ld_done_out,
  // Model register write
  input wire msr_wr_in,
  input wire [31:0] msr_addr_in,
  input wire [63:0] msr_data_in,
  // Base write instruction
  input wire bw_valid_in,
  input wire bw_sel_b_in,
  input wire bw_op32_in,
  input wire [63:0] bw_data_in,
  output reg base_wr_done_out,
  // Memory access
  input wire acc_valid_in,
  input wire [1:0] acc_kind_in,
  input wire acc_ovr_in,
  input wire [2:0] acc_ovr_seg_in,
  input wire [63:0] acc_ea_in,
  output reg acc_done_out,
  output reg [63:0] lin_addr_out,
  output reg [1:0] acc_priv_out,
  // Readback
  input wire [2:0] rd_seg_in,
  output reg [15:0] rd_sel_out,
  output reg [63:0] rd_base_a_out,
  output reg [63:0] rd_base_b_out,
  // Status
  output reg [1:0] current_privilege_out,
  output reg cs_long_out,
  output reg cs_dsize_out,
  output reg fault_out,
  output reg [1:0] fault_kind_out
);

////////////////////////////////////////////////////////////////////////////////
// Reset synchroniser

reg rst_meta_ff;
reg rst_sync_ff;
wire rst_n;

// Assertion acts at once; release waits two edges
always @(posedge clock_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    rst_meta_ff <= 1'b0;
    rst_sync_ff <= 1'b0;
  end
  else
  begin
    rst_meta_ff <= 1'b1;
    rst_sync_ff <= rst_meta_ff;
  end
end

assign rst_n = rst_sync_ff;

////////////////////////////////////////////////////////////////////////////////
// Canonical address check

// Bits 63 down to 47 all match: a 48-bit virtual space
function canon;
  input [63:0] a;
  begin
    canon = (&a[63:`SSR_CANON_LO]) | ~(|a[63:`SSR_CANON_LO]);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Load, base write and privilege control

reg [1:0] current_privilege_ff;
wire ld_null;
wire ld_bad;
wire ld_ok;
wire msr_a;
wire msr_b;
wire msr_ok;
wire msr_bad;
wire [63:0] bw_val;
wire bw_ok;
wire bw_bad;
wire [1:0] bwr;
wire [63:0] bwr_data;
wire ld_flt;
wire bw_lost;
wire bw_done;

assign ld_null = (ld_sel_in[`SSR_IDX_HI:`SSR_IDX_LO] == `SSR_IDX_NULL) &&
                 !ld_sel_in[`SSR_TI];
// Stack null allowed only in 64-bit mode below user privilege
assign ld_bad = (ld_seg_in > `SSR_SEG_TB) ||
                (ld_null && (ld_seg_in == `SSR_SEG_CS)) ||
                (ld_null && (ld_seg_in == `SSR_SEG_SS) &&
                 (!mode64_in || (current_privilege_ff == `SSR_PRIV_USER)));
assign ld_ok = ld_valid_in && !ld_bad;

// Other model register addresses are ignored silently
assign msr_a = msr_wr_in && (msr_addr_in == `SSR_MSR_BASE_A);
assign msr_b = msr_wr_in && (msr_addr_in == `SSR_MSR_BASE_B);
assign msr_ok = (current_privilege_ff == `SSR_PRIV_SUPER) &&
                canon(msr_data_in);
assign msr_bad = (msr_a || msr_b) && !msr_ok;

assign bw_val = bw_op32_in ? {`SSR_ZERO32, bw_data_in[31:0]} : bw_data_in;
assign bw_ok = user_base_write_enable_in && mode64_in && canon(bw_val);
assign bw_bad = bw_valid_in && !bw_ok;

// Model register write wins if both arrive together
assign bwr[0] = (msr_a && msr_ok) ||
                (!(msr_a || msr_b) && bw_valid_in && bw_ok && !bw_sel_b_in);
assign bwr[1] = (msr_b && msr_ok) ||
                (!(msr_a || msr_b) && bw_valid_in && bw_ok && bw_sel_b_in);
assign bwr_data = (msr_a || msr_b) ? msr_data_in : bw_val;
assign ld_flt = ld_valid_in && ld_bad;
// A same-cycle load into that thread segment wins, so no done pulse
assign bw_lost = ld_ok && (((ld_seg_in == `SSR_SEG_TA) && bwr[0]) ||
                           ((ld_seg_in == `SSR_SEG_TB) && bwr[1]));
assign bw_done = (bwr[0] || bwr[1]) && !bw_lost;

always @(posedge clock_in or negedge rst_n)
begin
  if (!rst_n)
    current_privilege_ff <= `SSR_PRIV_SUPER;
  else if (ld_ok && (ld_seg_in == `SSR_SEG_CS))
    current_privilege_ff <= ld_desc_in[`SSR_D_ATTR_LO + `SSR_AT_DPL_HI:
                                       `SSR_D_ATTR_LO + `SSR_AT_DPL_LO];
end

////////////////////////////////////////////////////////////////////////////////
// Segment register file

wire [15:0] seg_sel_w [0:`SSR_NSEG-1];
wire [63:0] seg_base_w [0:`SSR_NSEG-1];
wire [19:0] seg_lim_w [0:`SSR_NSEG-1];
wire [15:0] seg_attr_w [0:`SSR_NSEG-1];

genvar gi;
generate
  for (gi = 0; gi < `SSR_NSEG; gi = gi + 1)
  begin : g_seg
    localparam integer SEG_NUM = gi;
    localparam [2:0] IDX = SEG_NUM[2:0];
    localparam THR = (IDX >= `SSR_SEG_TA);
    reg [15:0] sel_ff;
    reg [63:0] base_ff;
    reg [19:0] lim_ff;
    reg [15:0] attr_ff;
    wire hit_ld;
    wire hit_bw;
    // Refused loads never reach the flops
    assign hit_ld = ld_ok && (ld_seg_in == IDX);
    assign hit_bw = (IDX == `SSR_SEG_TA) ? bwr[0] : ((IDX == `SSR_SEG_TB) ? bwr[1] : 1'b0);
    // Mode inputs reach these flops only through the load and base-write enables: contents survive mode switches
    always @(posedge clock_in or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sel_ff <= `SSR_RST_SEL;
        base_ff <= `SSR_RST_BASE;
        lim_ff <= `SSR_RST_LIM;
        attr_ff <= `SSR_RST_ATTR;
      end
      else if (hit_ld)
      begin
        sel_ff <= ld_sel_in;
        if (!(THR && ld_null))
        begin
          base_ff <= {`SSR_ZERO32,
                      ld_desc_in[`SSR_D_BASE_HI_HI:`SSR_D_BASE_HI_LO],
                      ld_desc_in[`SSR_D_BASE_LO_HI:`SSR_D_BASE_LO_LO]};
          lim_ff <= {ld_desc_in[`SSR_D_LIM_HI_HI:`SSR_D_LIM_HI_LO],
                     ld_desc_in[`SSR_D_LIM_LO_HI:`SSR_D_LIM_LO_LO]};
          attr_ff <= ld_desc_in[`SSR_D_ATTR_HI:`SSR_D_ATTR_LO];
        end
      end
      else if (hit_bw)
        base_ff <= bwr_data;
    end
    assign seg_sel_w[gi] = sel_ff;
    assign seg_base_w[gi] = base_ff;
    assign seg_lim_w[gi] = lim_ff;
    assign seg_attr_w[gi] = attr_ff;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Address generation and checks

reg [2:0] a_seg;
reg a_seg_ok;
reg [15:0] a_sel;
reg [63:0] a_base;
reg [31:0] a_lim;
reg [15:0] a_attr;
reg a_null;
reg [63:0] a_lin;
reg a_fault;
reg [31:0] a_sum32;
wire acc_ok;
wire acc_flt;
wire [1:0] a_rpl;

always @*
begin
  a_seg = `SSR_SEG_DS;
  a_seg_ok = 1'b1;
  a_sel = `SSR_RST_SEL;
  a_base = `SSR_RST_BASE;
  a_lim = `SSR_ZERO32;
  a_attr = `SSR_RST_ATTR;
  a_null = 1'b0;
  a_lin = `SSR_RST_BASE;
  a_fault = 1'b0;
  a_sum32 = `SSR_ZERO32;
  // Only plain data accesses may take an override
  case (acc_kind_in)
    `SSR_ACC_FETCH: a_seg = `SSR_SEG_CS;
    `SSR_ACC_STRDST: a_seg = `SSR_SEG_ES;
    `SSR_ACC_STACK: a_seg = `SSR_SEG_SS;
    `SSR_ACC_DATA: a_seg = acc_ovr_in ? acc_ovr_seg_in : `SSR_SEG_DS;
    default: a_seg = `SSR_SEG_DS;
  endcase
  if (a_seg > `SSR_SEG_TB)
  begin
    a_seg_ok = 1'b0;
    a_seg = `SSR_SEG_DS;
  end
  a_sel = seg_sel_w[a_seg];
  a_base = seg_base_w[a_seg];
  a_attr = seg_attr_w[a_seg];
  // Granularity scales the 20-bit limit to 4 KiB units
  if (a_attr[`SSR_AT_G])
    a_lim = {seg_lim_w[a_seg], `SSR_ONES12};
  else
    a_lim = {`SSR_ZERO12, seg_lim_w[a_seg]};
  a_null = (a_sel[`SSR_IDX_HI:`SSR_IDX_LO] == `SSR_IDX_NULL) && !a_sel[`SSR_TI];
  if (mode64_in)
  begin
    // Only thread segments carry a base; others count as zero
    if ((a_seg == `SSR_SEG_TA) || (a_seg == `SSR_SEG_TB))
      a_lin = a_base + acc_ea_in;
    else
      a_lin = acc_ea_in;
    a_fault = !canon(a_lin) || !a_seg_ok;
  end
  else
  begin
    // Upper base bits are ignored here whatever they hold
    a_sum32 = a_base[31:0] + acc_ea_in[31:0];
    a_lin = {`SSR_ZERO32, a_sum32};
    // Expand-down segments and access size are not modelled
    a_fault = a_null || (acc_ea_in[31:0] > a_lim) || !a_seg_ok;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Request outcomes

assign acc_ok = acc_valid_in && !a_fault;
assign acc_flt = acc_valid_in && a_fault;
assign a_rpl = a_sel[`SSR_RPL_HI:`SSR_RPL_LO];

////////////////////////////////////////////////////////////////////////////////
// Registered outputs

always @(posedge clock_in or negedge rst_n)
begin
  if (!rst_n)
  begin
    dec_valid_out <= 1'b0;
    desc_addr_out <= `SSR_RST_BASE;
    ld_done_out <= 1'b0;
    base_wr_done_out <= 1'b0;
    acc_done_out <= 1'b0;
    lin_addr_out <= `SSR_RST_BASE;
    acc_priv_out <= `SSR_PRIV_SUPER;
    rd_sel_out <= `SSR_RST_SEL;
    rd_base_a_out <= `SSR_RST_BASE;
    rd_base_b_out <= `SSR_RST_BASE;
    current_privilege_out <= `SSR_PRIV_SUPER;
    cs_long_out <= 1'b0;
    cs_dsize_out <= 1'b0;
    fault_out <= 1'b0;
    fault_kind_out <= `SSR_FK_NONE;
  end
  else
  begin
    dec_valid_out <= dec_valid_in;
    if (dec_valid_in)
      // Eight-byte slots even for wide long-mode entries
      desc_addr_out <= (dec_sel_in[`SSR_TI] ? ldt_base_in : gdt_base_in) +
                       {`SSR_ZERO48, dec_sel_in[`SSR_IDX_HI:`SSR_IDX_LO],
                        `SSR_DESC_ALIGN};
    ld_done_out <= ld_ok;
    base_wr_done_out <= bw_done;
    acc_done_out <= acc_ok;
    if (acc_ok)
    begin
      lin_addr_out <= a_lin;
      // Weaker of current and requester privilege drives the checks
      acc_priv_out <= (a_rpl > current_privilege_ff) ? a_rpl :
                      current_privilege_ff;
    end
    // Hidden fields other than the thread bases and the code L and D bits are not read out
    rd_sel_out <= (rd_seg_in > `SSR_SEG_TB) ? `SSR_RST_SEL : seg_sel_w[rd_seg_in];
    rd_base_a_out <= seg_base_w[`SSR_SEG_TA];
    rd_base_b_out <= seg_base_w[`SSR_SEG_TB];
    current_privilege_out <= current_privilege_ff;
    cs_long_out <= seg_attr_w[`SSR_SEG_CS][`SSR_AT_L];
    cs_dsize_out <= seg_attr_w[`SSR_SEG_CS][`SSR_AT_D];
    // Faulting requests were already kept off every state update
    fault_out <= ld_flt || msr_bad || bw_bad || acc_flt;
    if (ld_flt)
      fault_kind_out <= `SSR_FK_LOAD;
    else if (msr_bad || bw_bad)
      fault_kind_out <= `SSR_FK_BASEWR;
    else if (acc_flt)
      fault_kind_out <= `SSR_FK_ACCESS;
    else
      fault_kind_out <= `SSR_FK_NONE;
  end
end

endmodule

// ===== test/ssr_desc_model.sv
// Descriptor source standing in for the core's table fetch.
// Assumes the selector is held while the load request is up.
module ssr_desc_model (
  // Selector in, entry out
  input wire [15:0] sel_in,
  output logic [63:0] desc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] base;
  // Base is index times 4K so each entry is told apart
  assign base = {7'h00, sel_in[15:3], 12'h000};
  // Privilege mirrors the selector; index bit 1 gives D, bit 0 gives L; 4 GB limit
  assign desc_out = {base[31:24], 1'b1, sel_in[4:3], 1'b0, 4'hf, 1'b1, sel_in[1:0], 5'h13,
    base[23:0], 16'hffff};
endmodule

// ===== test/ssr_unit_monitor.sv
// Port checker for ssr_unit.
// Assumes the bind below; every signal sits on clock_in.
module ssr_chk (
  input wire clock_in,
  input wire resetn_in,
  input wire mode64_in,
  input wire user_base_write_enable_in,
  input wire dec_valid_in,
  input wire [15:0] dec_sel_in,
  input wire [63:0] gdt_base_in,
  input wire [63:0] ldt_base_in,
  input wire dec_valid_out,
  input wire [63:0] desc_addr_out,
  input wire ld_valid_in,
  input wire [2:0] ld_seg_in,
  input wire [15:0] ld_sel_in,
  input wire ld_done_out,
  input wire msr_wr_in,
  input wire bw_valid_in,
  input wire acc_valid_in,
  input wire [1:0] acc_kind_in,
  input wire [63:0] acc_ea_in,
  input wire acc_done_out,
  input wire [63:0] lin_addr_out,
  input wire fault_out,
  input wire [1:0] fault_kind_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  property p_dec_pulse; dec_valid_in |=> dec_valid_out; endproperty
  a_dec_pulse: assert property (p_dec_pulse)
    else $error("decode answer missing");
  property p_dec_addr; dec_valid_in |=> desc_addr_out == (($past(dec_sel_in[2]) ?
    $past(ldt_base_in) : $past(gdt_base_in)) + {48'h0, $past(dec_sel_in[15:3]), 3'h0});
  endproperty
  a_dec_addr: assert property (p_dec_addr)
    else $error("descriptor address wrong");
  property p_fault_kind; fault_out == (fault_kind_out != 2'h0); endproperty
  a_fault_kind: assert property (p_fault_kind)
    else $error("fault kind and pulse disagree");
  property p_cs_null; ld_valid_in && ld_seg_in == 3'h1 && ld_sel_in[15:2] == 14'h0
    |=> fault_out && fault_kind_out == 2'h1 && !ld_done_out; endproperty
  a_cs_null: assert property (p_cs_null)
    else $error("null code load accepted");
  property p_ss_null; ld_valid_in && ld_seg_in == 3'h2 && ld_sel_in[15:2] == 14'h0
    && !mode64_in |=> fault_out && !ld_done_out; endproperty
  a_ss_null: assert property (p_ss_null)
    else $error("null stack load accepted outside 64-bit mode");
  property p_data_ld; ld_valid_in && (ld_seg_in == 3'h3 || ld_seg_in == 3'h4)
    |=> ld_done_out && !fault_out; endproperty
  a_data_ld: assert property (p_data_ld)
    else $error("data segment load refused");
  property p_flat; acc_valid_in && mode64_in && acc_kind_in != 2'h1 && !ld_valid_in
    && !msr_wr_in && !bw_valid_in && acc_ea_in[63:47] == 17'h0
    |=> acc_done_out && lin_addr_out == $past(acc_ea_in); endproperty
  a_flat: assert property (p_flat)
    else $error("flat access address wrong");
  property p_bw_off; bw_valid_in && !user_base_write_enable_in && !msr_wr_in
    && !ld_valid_in |=> fault_out && fault_kind_out == 2'h3; endproperty
  a_bw_off: assert property (p_bw_off)
    else $error("disabled base write not refused");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ssr_unit ssr_chk u_chk (.*);

// ===== test/testbench.sv
// Self-checking bench for ssr_unit with a descriptor source.
// Assumes a 25 MHz core clock and same-clock requests.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0, resetn_in = 1'b0, mode64_in = 1'b0, user_base_write_enable_in = 1'b0;
  logic dec_valid_in = 1'b0, ld_valid_in = 1'b0, msr_wr_in = 1'b0, bw_valid_in = 1'b0;
  logic bw_sel_b_in = 1'b0, bw_op32_in = 1'b0, acc_valid_in = 1'b0, acc_ovr_in = 1'b0;
  logic [15:0] dec_sel_in = 16'h0, ld_sel_in = 16'h0, rd_sel_out;
  logic [63:0] gdt_base_in = 64'h10000, ldt_base_in = 64'h200000000000, ld_desc_in;
  logic [63:0] msr_data_in = 64'h0, bw_data_in = 64'h0, acc_ea_in = 64'h0;
  logic [2:0] ld_seg_in = 3'h0, acc_ovr_seg_in = 3'h0, rd_seg_in = 3'h0;
  logic [31:0] msr_addr_in = 32'h0;
  logic [1:0] acc_kind_in = 2'h0, acc_priv_out, current_privilege_out, fault_kind_out;
  logic dec_valid_out, ld_done_out, base_wr_done_out, acc_done_out;
  logic cs_long_out, cs_dsize_out, fault_out;
  logic [63:0] desc_addr_out, lin_addr_out, rd_base_a_out, rd_base_b_out;
  int err_total = 0, n_tests = 0;
  // Selector beside the address it should decode to
  logic [79:0] rows [4] = '{{16'h0000, 64'h10000}, {16'hfffb, 64'h1fff8},
    {16'h000c, 64'h200000000008}, {16'hffff, 64'h20000000fff8}};
  always #20 clock_in = ~clock_in;
  ssr_unit dut (.*);
  ssr_desc_model u_src (.sel_in(ld_sel_in), .desc_out(ld_desc_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic flt(input logic [1:0] k);
    check("fault", {fault_out, fault_kind_out}, {k != 2'h0, k});
  endtask
  task automatic ld(input logic [2:0] s, input logic [15:0] v);
    @(posedge clock_in);
    ld_valid_in <= 1'b1;
    ld_seg_in <= s;
    ld_sel_in <= v;
    @(posedge clock_in);
    ld_valid_in <= 1'b0;
    #1;
  endtask
  task automatic msr(input logic [31:0] a, input logic [63:0] d);
    @(posedge clock_in);
    msr_wr_in <= 1'b1;
    msr_addr_in <= a;
    msr_data_in <= d;
    @(posedge clock_in);
    msr_wr_in <= 1'b0;
    #1;
  endtask
  task automatic bw(input logic b, input logic o, input logic [63:0] d);
    @(posedge clock_in);
    bw_valid_in <= 1'b1;
    bw_sel_b_in <= b;
    bw_op32_in <= o;
    bw_data_in <= d;
    @(posedge clock_in);
    bw_valid_in <= 1'b0;
    #1;
  endtask
  task automatic acc(input logic [1:0] k, input logic o, input logic [2:0] s, input logic [63:0] e);
    @(posedge clock_in);
    acc_valid_in <= 1'b1;
    acc_kind_in <= k;
    acc_ovr_in <= o;
    acc_ovr_seg_in <= s;
    acc_ea_in <= e;
    @(posedge clock_in);
    acc_valid_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] s);
    @(posedge clock_in);
    rd_seg_in <= s;
    @(posedge clock_in);
    #1;
  endtask
  task automatic mode(input logic m, input logic en);
    @(posedge clock_in);
    mode64_in <= m;
    user_base_write_enable_in <= en;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Guards against a hang in any fixed-latency step
  initial
  begin
    repeat (5000) @(posedge clock_in);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(3'h1);
    check("cs_sel", rd_sel_out, 64'h0);
    check("base_a", rd_base_a_out, 64'h0);
    foreach (rows[i])
    begin
      @(posedge clock_in);
      dec_valid_in <= 1'b1;
      dec_sel_in <= rows[i][79:64];
      @(posedge clock_in);
      dec_valid_in <= 1'b0;
      #1;
      check("desc_addr", desc_addr_out, rows[i][63:0]);
    end
    $display("Test decode done");
    msr(32'hc0000100, 64'hffff800012345678);
    check("msr_done", base_wr_done_out, 64'h1);
    for (int s = 0; s < 6; s++)
    begin
      ld(s[2:0], {10'h0, s[2:0] + 3'h1, 3'h0});
      check("ld_done", ld_done_out, 64'h1);
      rd(s[2:0]);
      check("rd_sel", rd_sel_out, {10'h0, s[2:0] + 3'h1, 3'h0});
    end
    check("base_a", rd_base_a_out, 64'h5000);
    check("cs_attr", {cs_long_out, cs_dsize_out}, 64'h1);
    ld(3'h1, 16'h0003);
    flt(2'h1);
    rd(3'h1);
    check("cs_kept", rd_sel_out, 64'h10);
    ld(3'h2, 16'h0000);
    flt(2'h1);
    $display("Test loads done");
    mode(1'b1, 1'b1);
    ld(3'h2, 16'h0000);
    check("ss_null64", ld_done_out, 64'h1);
    rd(3'h3);
    check("ds_kept", rd_sel_out, 64'h20);
    msr(32'hc0000101, 64'hffff800000001000);
    acc(2'h1, 1'b1, 3'h5, 64'h00007ffffffff000);
    check("lin_wrap", lin_addr_out, 64'h0);
    acc(2'h1, 1'b0, 3'h0, 64'hffff800000000040);
    check("lin_ds", lin_addr_out, 64'hffff800000000040);
    acc(2'h1, 1'b0, 3'h0, 64'h0001000000000000);
    flt(2'h2);
    acc(2'h0, 1'b0, 3'h0, 64'h1000);
    check("lin_cs", lin_addr_out, 64'h1000);
    bw(1'b0, 1'b1, 64'hdeadbeef12345678);
    rd(3'h4);
    check("bw32", rd_base_a_out, 64'h12345678);
    bw(1'b1, 1'b0, 64'h0080000000000000);
    flt(2'h3);
    msr(32'hc0000100, 64'h0000800000000000);
    flt(2'h3);
    mode(1'b1, 1'b0);
    bw(1'b0, 1'b0, 64'h10);
    flt(2'h3);
    rd(3'h5);
    check("base_b", rd_base_b_out, 64'hffff800000001000);
    $display("Test 64-bit done");
    msr(32'hc0000100, 64'hffff800000000100);
    mode(1'b0, 1'b0);
    acc(2'h1, 1'b1, 3'h4, 64'hffffffff00000010);
    check("lin_compat", lin_addr_out, 64'h110);
    acc(2'h3, 1'b0, 3'h0, 64'h10);
    flt(2'h2);
    ld(3'h4, 16'h0003);
    rd(3'h4);
    check("base_null", rd_base_a_out, 64'hffff800000000100);
    acc(2'h1, 1'b1, 3'h4, 64'h10);
    flt(2'h2);
    ld(3'h3, 16'h0022);
    acc(2'h1, 1'b0, 3'h0, 64'h10);
    check("lin_rpl", lin_addr_out, 64'h4010);
    check("acc_priv", acc_priv_out, 64'h2);
    ld(3'h1, 16'h001b);
    rd(3'h1);
    check("cpl", current_privilege_out, 64'h3);
    check("cs_attr", {cs_long_out, cs_dsize_out}, 64'h3);
    msr(32'hc0000101, 64'h0);
    flt(2'h3);
    $display("Test compat and privilege done");
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    check("rst_priv", current_privilege_out, 64'h0);
    check("rst_base_b", rd_base_b_out, 64'h0);
    $display("Test reset done");
    report_and_stop();
  end
endmodule
